// File: hdl/clkdiv_pkg.sv
// Purpose: shared constants and carriers for the input clock divider block
// Assumes: clk is the double-rate sample clock, 100 MHz in this model
// Notes: figures below are shared; therm31, therm15 and the checker repeat widths as literals
// Notes on behaviour
// - Divide double-rate clock by two internally
// - Drive delayed half-rate clock on output pin
// - Output latch updates on coinciding rising edge
// - Reset held high forces half-rate output high
// - After reset: first edge low, next high+load
// - Reset release enables output, low next edge
// - Late release adds one double-rate cycle delay
// - Toggle half-rate output every double-rate edge
// - Capture data on edge before output rise
// - Unsigned 14-bit codes, all ones near full-scale
// - Five top, four middle, five binary low bits
package clkdiv_pkg;
    // ==========================================================
    // Widths and segmentation
    localparam int CODE_W = 14;
    localparam int TOP_W = 5;
    localparam int MID_W = 4;
    localparam int LOW_W = CODE_W - TOP_W - MID_W;
    localparam int TOP_UNITS = 31;
    localparam int MID_UNITS = 15;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 10000;
    localparam int LATE_RELEASE_PS = 600;
    localparam int FIFO_DEPTH = 16;
    // ==========================================================
    // Reset values
    localparam logic HALF_RST = 1'b1;
    localparam logic [13:0] CODE_RST = 14'h0000;

    typedef struct packed {
        logic [TOP_UNITS-1:0] top_on;
        logic [MID_UNITS-1:0] mid_on;
        logic [LOW_W-1:0] low_on;
    } segments_s;
endpackage

// File: hdl/sample_fifo.sv
// Purpose: flip-flop FIFO for input samples
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty are exact; no overwrite when full
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // ==========================================================
    // Status
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // Storage is written only, never reset, to save reset fanout
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap naturally because depth is a power of two
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

// File: hdl/dac_input_clock_divider_sync.sv
// Purpose: divide-by-two input clocking, reset alignment and segment decode
// Assumes: clk is the double-rate clock; reset_pin and late flag are external
// Notes: analog switching is modelled as per-unit enable bits for the top and middle groups, binary-weighted bits for the low group
`timescale 1ns/100ps
`default_nettype none
module dac_input_clock_divider_sync #(
    parameter int CODE_W = clkdiv_pkg::CODE_W,
    parameter int DEPTH = clkdiv_pkg::FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Alignment pins
    input wire logic reset_pin,
    input wire logic release_late,
    // Sample source
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [CODE_W-1:0] sample_code,
    // Clock status pin
    output logic lock_or_half_rate_clock_out,
    // Converter core
    output logic [CODE_W-1:0] latched_code,
    output clkdiv_pkg::segments_s current_out_true,
    output clkdiv_pkg::segments_s current_out_complement
);
    typedef enum logic [1:0] {HELD, HOLDOFF, RUN} div_state_e;

    // Thermometer decode: value k turns on k low-order units
    function automatic logic [30:0] therm31(input logic [4:0] k);
        logic [30:0] t;
        t = '0;
        for (int i = 0; i < 31; i++)
        begin
            t[i] = (i < int'(k));
        end
        return t;
    endfunction

    function automatic logic [14:0] therm15(input logic [3:0] k);
        logic [14:0] t;
        t = '0;
        for (int i = 0; i < 15; i++)
        begin
            t[i] = (i < int'(k));
        end
        return t;
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic rst_meta;
    logic rst_sync;
    logic late_meta;
    logic late_sync;

    // Two stages before anything reads the asynchronous pins
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rst_meta <= 1'b1;
            rst_sync <= 1'b1;
            late_meta <= 1'b0;
            late_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= reset_pin;
            rst_sync <= rst_meta;
            late_meta <= release_late;
            late_sync <= late_meta;
        end
    end

    // ==========================================================
    // Divider
    div_state_e state;
    div_state_e next_state;
    logic half;
    logic next_half;
    logic half_dly;

    // Release sampled late costs one extra cycle before the first high
    always_comb
    begin
        next_state = state;
        next_half = half;
        case (state)
            HELD:
            begin
                next_half = clkdiv_pkg::HALF_RST;
                if (!rst_sync)
                begin
                    next_state = late_sync ? HOLDOFF : RUN;
                    next_half = 1'b0;
                end
            end
            HOLDOFF:
            begin
                next_half = 1'b0;
                next_state = RUN;
            end
            RUN:
            begin
                next_half = ~half;
            end
            default:
            begin
                next_state = HELD;
            end
        endcase
        if (rst_sync)
        begin
            next_state = HELD;
            next_half = clkdiv_pkg::HALF_RST;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= HELD;
            half <= clkdiv_pkg::HALF_RST;
            half_dly <= clkdiv_pkg::HALF_RST;
        end
        else
        begin
            state <= next_state;
            half <= next_half;
            half_dly <= half;
        end
    end

    assign lock_or_half_rate_clock_out = half_dly;

    // ==========================================================
    // Input path and latch
    // Load happens on the edge where the half clock rises
    wire load_edge = (state == RUN) && !half && next_half;
    wire fifo_valid;
    wire [CODE_W-1:0] fifo_data;
    logic [CODE_W-1:0] code;

    sample_fifo #(
        .WIDTH(CODE_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_code),
        .out_valid(fifo_valid),
        .out_ready(load_edge),
        .out_data(fifo_data)
    );

    // An empty FIFO holds the last code rather than glitching to zero
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            code <= clkdiv_pkg::CODE_RST;
        end
        else if (load_edge && fifo_valid)
        begin
            code <= fifo_data;
        end
    end

    assign latched_code = code;

    // ==========================================================
    // Segment decode
    wire [clkdiv_pkg::TOP_W-1:0] top_k = code[CODE_W-1 -: clkdiv_pkg::TOP_W];
    wire [clkdiv_pkg::MID_W-1:0] mid_k = code[clkdiv_pkg::LOW_W +: clkdiv_pkg::MID_W];
    wire [clkdiv_pkg::LOW_W-1:0] low_k = code[clkdiv_pkg::LOW_W-1:0];
    clkdiv_pkg::segments_s seg;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            seg <= '0;
        end
        else
        begin
            seg.top_on <= therm31(top_k);
            seg.mid_on <= therm15(mid_k);
            seg.low_on <= low_k;
        end
    end

    // Complement gets every unit the true side does not
    assign current_out_true = seg;
    assign current_out_complement = ~seg;
endmodule
`default_nettype wire

// File: tb/clkdiv_asserts.sv
// Purpose: port checker for the input clock divider
// Assumes: one clock; reset_pin reaches the divider two cycles late
// Notes: release timing is checked at exact cycle offsets, with no sync skew allowed
`timescale 1ns/100ps
`default_nettype none
module clkdiv_checker #(
    parameter int CODE_W = 14
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched pins
    input wire logic reset_pin,
    input wire logic release_late,
    input wire logic lock_or_half_rate_clock_out,
    input wire logic [CODE_W-1:0] latched_code,
    input wire clkdiv_pkg::segments_s current_out_true,
    input wire clkdiv_pkg::segments_s current_out_complement
);
    // ========================================
    // Short aliases
    wire pin = lock_or_half_rate_clock_out;
    wire [CODE_W-1:0] lc = latched_code;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ========================================
    // Divider and alignment
    hold_high_a: assert property (reset_pin [*5] |-> pin)
        else $error("half-rate pin low during reset");
    toggle_a: assert property ((!reset_pin) [*8] |-> pin != $past(pin))
        else $error("half-rate pin missed a toggle");
    period_a: assert property ($rose(pin) && !reset_pin |=> !pin ##1 pin)
        else $error("half-rate period not two cycles");
    // Two sync stages, the half register and the output register put the first low four edges on
    prompt_a: assert property (reset_pin [*6] ##1 (!reset_pin && !release_late)
        |-> ##4 !pin ##1 pin) else $error("prompt release sequence wrong");
    late_a: assert property (reset_pin [*6] ##1 (!reset_pin && release_late)
        |-> ##4 !pin [*2] ##1 pin) else $error("late release sequence wrong");
    load_edge_a: assert property (!$stable(lc) |=> $rose(pin))
        else $error("latch loaded off the half-rate rise");
    // ========================================
    // Segment decode, one cycle behind the latch
    top_seg_a: assert property (current_out_true.top_on ==
        31'((32'h1 << $past(lc[13:9])) - 32'h1)) else $error("top group wrong");
    mid_seg_a: assert property (current_out_true.mid_on ==
        15'((32'h1 << $past(lc[8:5])) - 32'h1)) else $error("middle group wrong");
    low_seg_a: assert property (current_out_true.low_on == $past(lc[4:0]))
        else $error("binary group wrong");
    compl_a: assert property (current_out_complement == ~current_out_true)
        else $error("complement output mismatch");
endmodule
bind dac_input_clock_divider_sync clkdiv_checker #(.CODE_W(CODE_W)) chk (.clk(clk),
    .srst(srst), .reset_pin(reset_pin), .release_late(release_late),
    .lock_or_half_rate_clock_out(lock_or_half_rate_clock_out), .latched_code(latched_code),
    .current_out_true(current_out_true), .current_out_complement(current_out_complement));
`default_nettype wire

// File: tb/sample_source.sv
// Purpose: data source feeding samples with gaps
// Assumes: valid/ready handshake taken at the rising edge
// Notes: consecutive codes always differ so loads are visible
`timescale 1ns/100ps
`default_nettype none
module sample_source (
    // Clock and control
    input wire logic clk,
    input wire logic en,
    // Sample stream
    output logic valid,
    input wire logic ready,
    output logic [13:0] code
);
    int seed = 32'h95BB7422;
    int n = 0;
    logic [13:0] nxt;
    initial
    begin
        valid = 1'b0;
        code = 14'h0000;
    end
    // An offer stays put until taken; new codes land just after the edge
    always @(posedge clk)
    begin
        if (!valid || ready)
        begin
            #1;
            nxt = (n == 0) ? 14'h3FFF : (n == 1) ? 14'h0000 : 14'($random(seed));
            if (nxt == code)
                nxt = nxt ^ 14'h0001;
            valid = en && (n < 2 || $random(seed) % 4 != 0);
            if (valid)
            begin
                code = nxt;
                n++;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: top bench for the input clock divider
// Assumes: 100 MHz clk, srst held 20 cycles
// Notes: a queue model follows every accepted sample to the latch
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic reset_pin = 1'b1;
    logic release_late = 1'b0;
    logic src_en = 1'b0;
    logic sample_valid, sample_ready, pin;
    logic [13:0] sample_code, latched_code;
    logic [13:0] prev_code = 14'h0000;
    clkdiv_pkg::segments_s seg_t, seg_c;
    int fail_count = 0;
    int n_checks = 0;
    logic [13:0] q[$];
    initial forever #5 clk = ~clk;
    dac_input_clock_divider_sync dut (.clk(clk), .srst(srst), .reset_pin(reset_pin),
        .release_late(release_late), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_code(sample_code), .lock_or_half_rate_clock_out(pin),
        .latched_code(latched_code), .current_out_true(seg_t), .current_out_complement(seg_c));
    sample_source src (.clk(clk), .en(src_en), .valid(sample_valid), .ready(sample_ready),
        .code(sample_code));
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Model: accepted samples reach the latch in order, segments follow
    always @(posedge clk)
    begin
        if (sample_valid && sample_ready && !srst)
            q.push_back(sample_code);
        if (!srst && latched_code !== prev_code)
            check("latched", latched_code, q.size() ? q.pop_front() : 32'hFFFFFFFF);
        if (!srst)
        begin
            check("top", seg_t.top_on, (32'h1 << prev_code[13:9]) - 32'h1);
            check("mid", seg_t.mid_on, (32'h1 << prev_code[8:5]) - 32'h1);
            check("low", seg_t.low_on, prev_code[4:0]);
            // Complement is derived from the code, not from the true output
            check("compl_top", seg_c.top_on,
                ~((32'h1 << prev_code[13:9]) - 32'h1) & 32'h7FFFFFFF);
            check("compl_mid", seg_c.mid_on,
                ~((32'h1 << prev_code[8:5]) - 32'h1) & 32'h00007FFF);
            check("compl_low", seg_c.low_on, {27'h0000000, ~prev_code[4:0]});
        end
        prev_code <= latched_code;
    end
    // Watchdog well beyond the expected run of about 700 cycles
    initial
    begin
        #50000;
        fail_count++;
        give_verdict();
    end
    // Fill while held, release promptly, drain, then a late release
    initial
    begin
        repeat (20) @(posedge clk);
        #1 srst = 1'b0;
        src_en = 1'b1;
        repeat (40) @(posedge clk);
        check("fill", q.size(), 16);
        check("ready", sample_ready, 1'b0);
        check("pin_hold", pin, 1'b1);
        #1 reset_pin = 1'b0;
        repeat (300) @(posedge clk);
        #1 src_en = 1'b0;
        for (int i = 0; i < 200 && q.size() > 0; i++)
            @(posedge clk);
        check("drained", q.size(), 0);
        #1 reset_pin = 1'b1;
        release_late = 1'b1;
        repeat (10) @(posedge clk);
        check("pin_hold", pin, 1'b1);
        #1 reset_pin = 1'b0;
        src_en = 1'b1;
        repeat (300) @(posedge clk);
        give_verdict();
    end
endmodule
`default_nettype wire
